// ---- logic/usart_rx_consts.vh ----
// constants for the serial receive buffer, status and interrupt block
// assumes an apb slave with 32-bit data; each register sits at four times its index
// ==========================================================
// Summary of operation
// - addressed-receive filter on: take address frames, drop data frames
// - master sync and spi modes drive serial clock, one period per bit
// - synchronised infrared event pulse can replace receive pin as decoder source
// - receive interrupt ORs enabled unread-data, start-detect and sync-error flags
// - tx-empty interrupt requests while enabled and transmit buffer empty
// - tx-done flag sets only when frame shifted out and buffer empty
// - events set flags; request is flag and enable, held until flag cleared
// - per-source interrupt enables live in the first control register
// - two-entry receive buffer; reading advances data and flags together
// - receive low byte at index 0 returns oldest data bits, resets zero
// - receive high byte: done, overflow, frame error, parity error, ninth bit
// - done flag high while unread data; disabling receiver flushes buffer
// - overflow when buffer full, shift char waiting, new start bit
// - overflow and frame error unused in master spi mode
// - frame error shows first stop bit of buffered character
// - only the first stop bit is checked for framing
// - frame type is first stop bit, or ninth bit for nine-bit frames
// - parity error set only when checking enabled, else reads zero
`ifndef USART_RX_CONSTS_VH
`define USART_RX_CONSTS_VH
// ==========================================================
// register indices
`define IDX_RX_DATA_LOW 4'h0
`define IDX_RX_DATA_HIGH 4'h1
`define IDX_TX_DATA_LOW 4'h2
`define IDX_TX_DATA_HIGH 4'h3
`define IDX_STATUS 4'h4
`define IDX_IRQ_CTRL 4'h5
`define IDX_ENABLE_CTRL 4'h6
`define IDX_FORMAT_CTRL 4'h7
`define IDX_BAUD_LOW 4'h8
`define IDX_BAUD_HIGH 4'h9
`define IDX_AUTOBAUD_CTRL 4'ha
`define IDX_DEBUG_CTRL 4'hb
`define IDX_EVENT_CTRL 4'hc
`define IDX_IR_TX_PULSE 4'hd
`define IDX_IR_RX_PULSE 4'he
// ==========================================================
// writable bit masks of control registers
`define MASK_AUTOBAUD 8'hc0
`define MASK_DEBUG 8'h01
`define MASK_EVENT 8'h01
`define MASK_IR_RX 8'h7f
// ==========================================================
// bit positions
`define HI_DONE 7
`define HI_OVF 6
`define HI_FRAMING_ERROR_FLAG 2
`define HI_PARITY_ERROR_FLAG 1
`define ST_TXDONE 6
`define ST_TXEMPTY 5
`define ST_RXSTART 4
`define ST_BADSYNC 3
`define CA_RXDONE_IE 7
`define CA_TXDONE_IE 6
`define CA_TXEMPTY_IE 5
`define CA_RXSTART_IE 4
`define CA_ABERR_IE 2
`define CB_RXEN 7
`define CB_TXEN 6
`define CB_SFDEN 4
`define CB_FILTER 0
`define CC_PARITY_ON 5
`define EV_IR_SEL 0
// ==========================================================
// field encodings and reset values
`define CMODE_SYNC 2'h1
`define CMODE_IR 2'h2
`define CMODE_SPI 2'h3
`define CHAR_SIZE_SELECT_9_LOW 3'h6
`define CHAR_SIZE_SELECT_9_HIGH 3'h7
`define RST_STATUS 8'h20
`define RST_REG 8'h00
// buffer entry: {ovf, framing_error_flag, parity_error_flag, data[8:0]}
`define ENTRY_W 12
`endif

// ---- logic/rx_char_fifo.v ----
// two-entry receive character buffer with its per-entry flags
// assumes the caller never pushes when full unless it pops in the same cycle
`timescale 1ns/10ps
module rx_char_fifo #(
  parameter WIDTH = 12
) (
  input wire pclk,
  input wire presetn,
  input wire flush,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output wire [WIDTH-1:0] head,
  output wire empty,
  output wire full
);
  reg [WIDTH-1:0] mem [0:1];
  reg rd_q;
  reg wr_q;
  reg [1:0] cnt_q;
  wire do_pop;
  wire do_push;

  // ==========================================================
  // occupancy
  assign empty = (cnt_q == 2'h0);
  assign full = (cnt_q == 2'h2);
  assign do_pop = pop & ~empty;
  assign do_push = push & (~full | do_pop);
  assign head = empty ? {WIDTH{1'b0}} : mem[rd_q];

  // pointers and count; flush empties at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (flush) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (do_pop)
        rd_q <= ~rd_q;
      if (do_push)
        wr_q <= ~wr_q;
      cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

  // storage, data and flags kept together
  always @(posedge pclk) begin
    if (do_push && !flush)
      mem[wr_q] <= push_data;
  end
endmodule

// ---- logic/usart_rx_buffer.v ----
// receive buffer, status flags, interrupt lines and event pins of the serial port
// assumes a receive shift engine and transmitter on pclk drive the strobes below
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`include "usart_rx_consts.vh"
module usart_rx_buffer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire rx_start,
  input wire rx_char_valid,
  input wire [8:0] rx_char_data,
  input wire rx_stop1,
  input wire rx_parity_bad,
  input wire autobaud_error,
  input wire tx_load,
  input wire tx_shift_done,
  output reg [8:0] tx_data_out,
  output wire tx_data_pending,
  input wire rxd_pin,
  input wire infrared_event_input,
  output reg ir_decoder_in,
  output reg serial_clock_out,
  output wire receive_irq_vector,
  output wire tx_empty_irq_vector,
  output wire tx_done_irq_vector,
  output wire [7:0] format_ctrl,
  output wire [15:0] bit_rate_div
);
  // ==========================================================
  // declarations
  reg [7:0] irq_ctrl_q;
  reg [7:0] enable_ctrl_q;
  reg [7:0] format_ctrl_q;
  reg [15:0] baud_q;
  reg [7:0] autobaud_q;
  reg [7:0] debug_q;
  reg [7:0] event_q;
  reg [7:0] ir_tx_q;
  reg [7:0] ir_rx_q;
  reg tx_high_q;
  reg tx_done_q;
  reg tx_empty_q;
  reg rx_start_q;
  reg bad_sync_q;
  reg hold_q;
  reg [`ENTRY_W-1:0] hold_data_q;
  reg ovf_pend_q;
  reg [15:0] clk_cnt_q;
  reg rxd_s1_q;
  reg rxd_s2_q;
  reg ir_s1_q;
  reg ir_s2_q;
  reg ir_s3_q;
  wire access;
  wire [3:0] idx;
  wire addr_bad;
  wire wr_en;
  wire rd_en;
  wire [7:0] wbyte;
  wire rx_enabled;
  wire spi_mode;
  wire nine_bit;
  wire frame_type;
  wire accepted;
  wire [`ENTRY_W-1:0] new_entry;
  wire ovf_set;
  wire fifo_empty;
  wire fifo_full;
  wire [`ENTRY_W-1:0] head;
  wire pop;
  wire room;
  wire push;
  wire [`ENTRY_W-1:0] push_data;
  wire [7:0] rx_high;
  wire [7:0] status;
  wire clk_master;

  // ==========================================================
  // apb decode: zero wait states, error on unmapped address
  function addr_mapped;
    input [7:0] a;
    begin
      addr_mapped = (a[1:0] == 2'h0) && (a[7:6] == 2'h0) && (a[5:2] != 4'hf);
    end
  endfunction

  assign access = psel & penable;
  assign idx = paddr[5:2];
  assign addr_bad = ~addr_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = access & addr_bad;
  assign wr_en = access & pwrite & ~addr_bad;
  assign rd_en = access & ~pwrite & ~addr_bad;
  assign wbyte = pwdata[7:0];
  assign format_ctrl = format_ctrl_q;
  assign bit_rate_div = baud_q;

  // ==========================================================
  // mode decode
  assign rx_enabled = enable_ctrl_q[`CB_RXEN];
  assign spi_mode = (format_ctrl_q[7:6] == `CMODE_SPI);
  assign nine_bit = (format_ctrl_q[2:0] == `CHAR_SIZE_SELECT_9_LOW) || (format_ctrl_q[2:0] == `CHAR_SIZE_SELECT_9_HIGH);
  assign clk_master = enable_ctrl_q[`CB_TXEN] &&
    ((format_ctrl_q[7:6] == `CMODE_SYNC) || (format_ctrl_q[7:6] == `CMODE_SPI));

  // ==========================================================
  // character intake
  // frame type from ninth bit or first stop bit
  assign frame_type = nine_bit ? rx_char_data[8] : rx_stop1;
  // filter drops data frames while active
  assign accepted = rx_char_valid & rx_enabled &
    ~(enable_ctrl_q[`CB_FILTER] & ~frame_type);
  // entry flags; only the first stop bit counts
  assign new_entry = {1'b0,
    ~rx_stop1 & ~spi_mode,
    rx_parity_bad & format_ctrl_q[`CC_PARITY_ON],
    rx_char_data};
  // overflow: both entries full, shift char waiting, new start
  assign ovf_set = rx_start & fifo_full & hold_q & ~spi_mode;

  // read of the low byte advances, or high byte in nine-bit low-first size
  assign pop = rd_en && ((format_ctrl_q[2:0] == `CHAR_SIZE_SELECT_9_LOW) ?
    (idx == `IDX_RX_DATA_HIGH) : (idx == `IDX_RX_DATA_LOW));
  assign room = ~fifo_full | (pop & ~fifo_empty);
  // held character goes first, keeping order
  assign push = rx_enabled & room & (hold_q | accepted);
  assign push_data = hold_q ? {ovf_pend_q | ovf_set, hold_data_q[`ENTRY_W-2:0]} : new_entry;

  rx_char_fifo #(
    .WIDTH(`ENTRY_W)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(~rx_enabled),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .head(head),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // shift-register stage that waits while the buffer is full
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 1'b0;
      hold_data_q <= {`ENTRY_W{1'b0}};
      ovf_pend_q <= 1'b0;
    end else if (!rx_enabled) begin
      hold_q <= 1'b0;
      ovf_pend_q <= 1'b0;
    end else begin
      if (hold_q && room) begin
        hold_q <= accepted;
        ovf_pend_q <= 1'b0;
        if (accepted)
          hold_data_q <= new_entry;
      end else if (accepted && !room) begin
        hold_q <= 1'b1;
        hold_data_q <= new_entry;
      end
      if (ovf_set && !(hold_q && room))
        ovf_pend_q <= 1'b1;
    end
  end

  // ==========================================================
  // control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ctrl_q <= `RST_REG;
      enable_ctrl_q <= `RST_REG;
      format_ctrl_q <= `RST_REG;
      baud_q <= 16'h0000;
      autobaud_q <= `RST_REG;
      debug_q <= `RST_REG;
      event_q <= `RST_REG;
      ir_tx_q <= `RST_REG;
      ir_rx_q <= `RST_REG;
    end else if (wr_en) begin
      case (idx)
        `IDX_IRQ_CTRL: irq_ctrl_q <= wbyte;
        `IDX_ENABLE_CTRL: enable_ctrl_q <= wbyte;
        `IDX_FORMAT_CTRL: format_ctrl_q <= wbyte;
        `IDX_BAUD_LOW: baud_q[7:0] <= wbyte;
        `IDX_BAUD_HIGH: baud_q[15:8] <= wbyte;
        `IDX_AUTOBAUD_CTRL: autobaud_q <= wbyte & `MASK_AUTOBAUD;
        `IDX_DEBUG_CTRL: debug_q <= wbyte & `MASK_DEBUG;
        `IDX_EVENT_CTRL: event_q <= wbyte & `MASK_EVENT;
        `IDX_IR_TX_PULSE: ir_tx_q <= wbyte;
        `IDX_IR_RX_PULSE: ir_rx_q <= wbyte & `MASK_IR_RX;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // transmit buffer and its flags
  assign tx_data_pending = ~tx_empty_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_out <= 9'h000;
      tx_high_q <= 1'b0;
      tx_empty_q <= 1'b1;
    end else begin
      if (wr_en && idx == `IDX_TX_DATA_HIGH)
        tx_high_q <= wbyte[0];
      // low byte write only taken while buffer empty
      if (wr_en && idx == `IDX_TX_DATA_LOW && tx_empty_q) begin
        tx_data_out <= {tx_high_q, wbyte};
        tx_empty_q <= 1'b0;
      end else if (wr_en && idx == `IDX_TX_DATA_HIGH && !tx_empty_q &&
                   format_ctrl_q[2:0] == `CHAR_SIZE_SELECT_9_LOW) begin
        tx_data_out[8] <= wbyte[0];
      end
      if (tx_load)
        tx_empty_q <= 1'b1;
    end
  end

  // ==========================================================
  // sticky status flags; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_done_q <= 1'b0;
      rx_start_q <= 1'b0;
      bad_sync_q <= 1'b0;
    end else begin
      if (tx_shift_done && tx_empty_q && !tx_load)
        tx_done_q <= 1'b1;
      else if (wr_en && idx == `IDX_STATUS && wbyte[`ST_TXDONE])
        tx_done_q <= 1'b0;
      if (rx_start && enable_ctrl_q[`CB_SFDEN] && !spi_mode)
        rx_start_q <= 1'b1;
      else if (wr_en && idx == `IDX_STATUS && wbyte[`ST_RXSTART])
        rx_start_q <= 1'b0;
      if (autobaud_error)
        bad_sync_q <= 1'b1;
      else if (wr_en && idx == `IDX_STATUS && wbyte[`ST_BADSYNC])
        bad_sync_q <= 1'b0;
    end
  end

  // ==========================================================
  // interrupt requests: flag and enable, held until flag clears
  assign receive_irq_vector = (~fifo_empty & irq_ctrl_q[`CA_RXDONE_IE]) |
    (rx_start_q & irq_ctrl_q[`CA_RXSTART_IE]) |
    (bad_sync_q & irq_ctrl_q[`CA_ABERR_IE]);
  assign tx_empty_irq_vector = tx_empty_q & irq_ctrl_q[`CA_TXEMPTY_IE];
  assign tx_done_irq_vector = tx_done_q & irq_ctrl_q[`CA_TXDONE_IE];

  // ==========================================================
  // read data
  // high byte: done, overflow, frame error, parity error, ninth bit
  assign rx_high = {~fifo_empty, head[11], 3'h0, head[10], head[9], head[8]};
  assign status = {~fifo_empty, tx_done_q, tx_empty_q, rx_start_q, bad_sync_q, 3'h0};

  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (idx)
        `IDX_RX_DATA_LOW: prdata[7:0] = head[7:0];
        `IDX_RX_DATA_HIGH: prdata[7:0] = rx_high;
        `IDX_TX_DATA_LOW: prdata[7:0] = tx_data_out[7:0];
        `IDX_STATUS: prdata[7:0] = status;
        `IDX_IRQ_CTRL: prdata[7:0] = irq_ctrl_q;
        `IDX_ENABLE_CTRL: prdata[7:0] = enable_ctrl_q;
        `IDX_FORMAT_CTRL: prdata[7:0] = format_ctrl_q;
        `IDX_BAUD_LOW: prdata[7:0] = baud_q[7:0];
        `IDX_BAUD_HIGH: prdata[7:0] = baud_q[15:8];
        `IDX_AUTOBAUD_CTRL: prdata[7:0] = autobaud_q;
        `IDX_DEBUG_CTRL: prdata[7:0] = debug_q;
        `IDX_EVENT_CTRL: prdata[7:0] = event_q;
        `IDX_IR_TX_PULSE: prdata[7:0] = ir_tx_q;
        `IDX_IR_RX_PULSE: prdata[7:0] = ir_rx_q;
        default: prdata = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // serial clock generator; toggles every baud_q+1 cycles in master modes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cnt_q <= 16'h0000;
      serial_clock_out <= 1'b0;
    end else if (!clk_master) begin
      clk_cnt_q <= 16'h0000;
      serial_clock_out <= 1'b0;
    end else if (clk_cnt_q >= baud_q) begin
      clk_cnt_q <= 16'h0000;
      serial_clock_out <= ~serial_clock_out;
    end else begin
      clk_cnt_q <= clk_cnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // pin synchronisers and infrared decoder source select
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      ir_s1_q <= 1'b0;
      ir_s2_q <= 1'b0;
      ir_s3_q <= 1'b0;
      ir_decoder_in <= 1'b0;
    end else begin
      rxd_s1_q <= rxd_pin;
      rxd_s2_q <= rxd_s1_q;
      ir_s1_q <= infrared_event_input;
      ir_s2_q <= ir_s1_q;
      ir_s3_q <= ir_s2_q;
      // event pulse replaces the inverted pin level when selected
      if (event_q[`EV_IR_SEL])
        ir_decoder_in <= ir_s2_q & ~ir_s3_q;
      else
        ir_decoder_in <= ~rxd_s2_q;
    end
  end
endmodule

// ---- tb/usart_rx_buffer_assertions.sv ----
// port checker for the serial receive buffer, status and interrupt block
// assumes it is bound to the top module and sees only a subset of its ports
`timescale 1ns/10ps
module usart_rx_buffer_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire rx_start,
  input wire rx_char_valid,
  input wire autobaud_error,
  input wire tx_load,
  input wire tx_shift_done,
  input wire tx_data_pending,
  input wire serial_clock_out,
  input wire receive_irq_vector,
  input wire tx_empty_irq_vector,
  input wire tx_done_irq_vector,
  input wire [7:0] format_ctrl
);
  // ==========================================================
  // access decode helpers
  wire acc = psel && penable;
  wire bad_adr = (paddr[1:0] != 2'h0) || (paddr[7:6] != 2'h0) || (paddr[5:2] == 4'hf);
  wire wr_ctla = acc && pwrite && (paddr == 8'h14);
  wire wr_txl = acc && pwrite && (paddr == 8'h08);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // bus answers
  bad_addr_a: assert property (acc && bad_adr |-> pslverr) else $error("unmapped access without error");
  good_addr_a: assert property (acc && !bad_adr |-> !pslverr) else $error("error on mapped access");
  idle_rdata_a: assert property (!acc |-> prdata == 32'h0) else $error("read data outside access");
  byte_rdata_a: assert property (prdata[31:8] == 24'h0) else $error("upper read data not zero");
  // ==========================================================
  // interrupt lines, transmit buffer and serial clock tied to their causes
  dre_irq_a: assert property (tx_empty_irq_vector |-> !tx_data_pending) else $error("tx empty irq with data");
  load_empty_a: assert property (tx_load && !wr_txl |=> !tx_data_pending) else $error("load left buffer full");
  txc_cause_a: assert property ($rose(tx_done_irq_vector) |-> $past(tx_shift_done) || $past(wr_ctla))
    else $error("tx done irq without cause");
  rxc_cause_a: assert property ($rose(receive_irq_vector)
    |-> $past(rx_char_valid) || $past(rx_start) || $past(autobaud_error) || $past(wr_ctla))
    else $error("receive irq without cause");
  sclk_idle_a: assert property (format_ctrl[7:6] != 2'h1 && format_ctrl[7:6] != 2'h3 |=> !serial_clock_out)
    else $error("serial clock outside master mode");
endmodule
bind usart_rx_buffer usart_rx_buffer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .rx_start(rx_start),
  .rx_char_valid(rx_char_valid), .autobaud_error(autobaud_error), .tx_load(tx_load),
  .tx_shift_done(tx_shift_done), .tx_data_pending(tx_data_pending), .serial_clock_out(serial_clock_out),
  .receive_irq_vector(receive_irq_vector), .tx_empty_irq_vector(tx_empty_irq_vector),
  .tx_done_irq_vector(tx_done_irq_vector), .format_ctrl(format_ctrl));

// ---- tb/rx_line_model.sv ----
// receive engine standing in for a remote node on the shared line
// assumes the testbench calls its tasks; strobes change just after pclk rises
`timescale 1ns/10ps
module rx_line_model (
  input wire pclk,
  output reg rx_start,
  output reg rx_char_valid,
  output reg [8:0] rx_char_data,
  output reg rx_stop1,
  output reg rx_parity_bad,
  output reg autobaud_error
);
  // ==========================================================
  // idle state
  initial begin
    rx_start = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 9'h0;
    rx_stop1 = 1'b1;
    rx_parity_bad = 1'b0;
    autobaud_error = 1'b0;
  end
  // one frame: start bit, gap for the bits, then the character strobe
  task frame(input [8:0] d, input stop, input parity_error_flag, input integer gap);
    begin
      @(posedge pclk);
      rx_start <= 1'b1;
      @(posedge pclk);
      rx_start <= 1'b0;
      repeat (gap) @(posedge pclk);
      rx_char_valid <= 1'b1;
      rx_char_data <= d;
      rx_stop1 <= stop;
      rx_parity_bad <= parity_error_flag;
      @(posedge pclk);
      rx_char_valid <= 1'b0;
      rx_char_data <= ~d; // stale data does not linger
      rx_stop1 <= ~stop;
      rx_parity_bad <= ~parity_error_flag;
      @(negedge pclk);
    end
  endtask
  // lone start bit or sync error pulse
  task strobe(input ab);
    begin
      @(posedge pclk);
      if (ab) begin
        autobaud_error <= 1'b1;
      end else begin
        rx_start <= 1'b1;
      end
      @(posedge pclk);
      autobaud_error <= 1'b0;
      rx_start <= 1'b0;
      @(negedge pclk);
    end
  endtask
endmodule

// ---- tb/usart_rx_buffer_tb.sv ----
// self-checking bench for the serial receive buffer block
// assumes apb master tasks here and the line model drive every input
`timescale 1ns/10ps
module usart_rx_buffer_tb;
  reg pclk, presetn, psel, penable, pwrite, tx_load, tx_shift_done, rxd_pin, infrared_event_input, last_err;
  reg [7:0] paddr;
  reg [31:0] pwdata, rdq;
  wire [31:0] prdata;
  wire pready, pslverr, rx_start, rx_char_valid, rx_stop1, rx_parity_bad, autobaud_error;
  wire tx_data_pending, ir_decoder_in, serial_clock_out, rx_irq, dre_irq, txc_irq;
  wire [8:0] rx_char_data, tx_data_out;
  wire [7:0] format_ctrl;
  wire [15:0] bit_rate_div;
  integer error_cnt, cmp_count, cyc, n;
  // ==========================================================
  // design and line model
  usart_rx_buffer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_start(rx_start),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data), .rx_stop1(rx_stop1),
    .rx_parity_bad(rx_parity_bad), .autobaud_error(autobaud_error), .tx_load(tx_load),
    .tx_shift_done(tx_shift_done), .tx_data_out(tx_data_out), .tx_data_pending(tx_data_pending),
    .rxd_pin(rxd_pin), .infrared_event_input(infrared_event_input), .ir_decoder_in(ir_decoder_in),
    .serial_clock_out(serial_clock_out), .receive_irq_vector(rx_irq), .tx_empty_irq_vector(dre_irq),
    .tx_done_irq_vector(txc_irq), .format_ctrl(format_ctrl), .bit_rate_div(bit_rate_div));
  rx_line_model PM (.pclk(pclk), .rx_start(rx_start), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_stop1(rx_stop1), .rx_parity_bad(rx_parity_bad),
    .autobaud_error(autobaud_error));
  // ==========================================================
  // shared tasks
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // one apb transfer; data taken at the edge where pready is high
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdq = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(rdq, {24'h0, exp});
    end
  endtask
  task txp(input ld);
    begin
      @(posedge pclk);
      if (ld) tx_load <= 1'b1;
      else tx_shift_done <= 1'b1;
      @(posedge pclk);
      tx_load <= 1'b0;
      tx_shift_done <= 1'b0;
      @(negedge pclk);
    end
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    begin
      rd(8'h10, 8'h20);
      rd(8'h00, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h14, 8'h00);
      $display("test reset done");
    end
  endtask
  task t_order;
    begin
      wr(8'h1c, 8'h27);
      wr(8'h14, 8'h80);
      wr(8'h18, 8'h80);
      PM.frame(9'h155, 1'b1, 1'b0, 2);
      PM.frame(9'h0aa, 1'b0, 1'b1, 6);
      chk({31'h0, rx_irq}, 1);
      rd(8'h04, 8'h81);
      rd(8'h00, 8'h55);
      rd(8'h04, 8'h86);
      rd(8'h00, 8'haa);
      rd(8'h04, 8'h00);
      chk({31'h0, rx_irq}, 0);
      $display("test order done");
    end
  endtask
  task t_modes;
    begin
      wr(8'h1c, 8'h07);
      PM.frame(9'h100, 1'b1, 1'b1, 1);
      rd(8'h04, 8'h81);
      rd(8'h00, 8'h00);
      wr(8'h1c, 8'h06);
      PM.frame(9'h1c3, 1'b1, 1'b0, 1);
      rd(8'h00, 8'hc3);
      rd(8'h04, 8'h81);
      rd(8'h04, 8'h00);
      $display("test modes done");
    end
  endtask
  task t_filter;
    begin
      wr(8'h1c, 8'h07);
      wr(8'h18, 8'h81);
      PM.frame(9'h066, 1'b1, 1'b0, 1);
      rd(8'h04, 8'h00);
      PM.frame(9'h1a5, 1'b1, 1'b0, 1);
      rd(8'h04, 8'h81);
      rd(8'h00, 8'ha5);
      wr(8'h18, 8'h80);
      PM.frame(9'h033, 1'b1, 1'b0, 1);
      rd(8'h04, 8'h80);
      rd(8'h00, 8'h33);
      $display("test filter done");
    end
  endtask
  task t_ovf;
    begin
      PM.frame(9'h011, 1'b1, 1'b0, 1);
      PM.frame(9'h022, 1'b1, 1'b0, 1);
      PM.frame(9'h033, 1'b1, 1'b0, 1);
      PM.strobe(1'b0);
      rd(8'h04, 8'h80);
      rd(8'h00, 8'h11);
      rd(8'h04, 8'h80);
      rd(8'h00, 8'h22);
      rd(8'h04, 8'hc0);
      rd(8'h00, 8'h33);
      rd(8'h04, 8'h00);
      PM.frame(9'h044, 1'b1, 1'b0, 1);
      wr(8'h18, 8'h00);
      rd(8'h04, 8'h00);
      $display("test overflow and flush done");
    end
  endtask
  task t_tx;
    begin
      wr(8'h14, 8'h20);
      chk({31'h0, dre_irq}, 1);
      wr(8'h08, 8'h5a);
      chk({31'h0, dre_irq}, 0);
      chk({23'h0, tx_data_out}, 32'h5a);
      chk({31'h0, tx_data_pending}, 1);
      txp(1'b0);
      rd(8'h10, 8'h00);
      txp(1'b1);
      chk({31'h0, dre_irq}, 1);
      txp(1'b0);
      wr(8'h14, 8'h60);
      chk({31'h0, txc_irq}, 1);
      rd(8'h10, 8'h60);
      wr(8'h10, 8'h40);
      chk({31'h0, txc_irq}, 0);
      $display("test transmit flags done");
    end
  endtask
  task t_start;
    begin
      wr(8'h18, 8'h90);
      wr(8'h14, 8'h14);
      PM.strobe(1'b0);
      chk({31'h0, rx_irq}, 1);
      rd(8'h10, 8'h30);
      wr(8'h10, 8'h10);
      chk({31'h0, rx_irq}, 0);
      PM.strobe(1'b1);
      chk({31'h0, rx_irq}, 1);
      wr(8'h10, 8'h08);
      chk({31'h0, rx_irq}, 0);
      $display("test start and sync done");
    end
  endtask
  task t_misc;
    begin
      wr(8'h30, 8'h01);
      n = 0;
      @(posedge pclk);
      infrared_event_input <= 1'b1;
      repeat (8) begin
        @(negedge pclk);
        n = n + ir_decoder_in;
      end
      chk(n, 1);
      @(posedge pclk);
      infrared_event_input <= 1'b0;
      rd(8'h3c, 8'h00);
      chk({31'h0, last_err}, 1);
      // master sync mode: clock toggles every baud+1 cycles
      wr(8'h20, 8'h02);
      wr(8'h18, 8'hc0);
      wr(8'h1c, 8'h40);
      chk({16'h0, bit_rate_div}, 32'h2);
      chk({24'h0, format_ctrl}, 32'h40);
      n = 0;
      repeat (12) begin
        @(negedge pclk);
        n = n + serial_clock_out;
      end
      chk(n, 6);
      // master spi mode: bad stop bit leaves frame error clear
      wr(8'h1c, 8'hc0);
      PM.frame(9'h012, 1'b0, 1'b0, 1);
      rd(8'h04, 8'h80);
      rd(8'h00, 8'h12);
      $display("test event and unmapped done");
    end
  endtask
  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  // ==========================================================
  // clock, hang guard and main sequence
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      final_report;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, tx_load, tx_shift_done, infrared_event_input} = 7'h0;
    rxd_pin = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    {error_cnt, cmp_count, cyc} = 96'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_order;
    t_modes;
    t_filter;
    t_ovf;
    t_tx;
    t_start;
    t_misc;
    final_report;
  end
endmodule
